// [hw/pst_pkg.sv]
package pst_pkg;
  localparam logic [4:0] PST_REG_STATUS = 5'h01;
  localparam logic [4:0] PST_REG_DETAIL = 5'h11;
  localparam logic [4:0] PST_REG_REMOTE = 5'h05;
  localparam int PST_BIT_T4 = 15;
  localparam int PST_BIT_TXFD = 14;
  localparam int PST_BIT_TXHD = 13;
  localparam int PST_BIT_TFD = 12;
  localparam int PST_BIT_THD = 11;
  localparam int PST_RSV_HI = 10;
  localparam int PST_RSV_LO = 7;
  localparam int PST_BIT_NOPRE = 6;
  localparam int PST_BIT_ANDONE = 5;
  localparam int PST_BIT_RFLT = 4;
  localparam int PST_BIT_ANABL = 3;
  localparam int PST_BIT_LINK = 2;
  localparam int PST_BIT_JAB = 1;
  localparam int PST_BIT_EXT = 0;
  localparam int PST_DET_RFLT = 1;
  localparam int PST_DET_LINK = 0;
  localparam int PST_LP_RFLT = 13;
  localparam logic [3:0] PST_CAP_RST = 4'hF;
  localparam logic [3:0] PST_RSV_RST = 4'h0;
  localparam logic PST_NOPRE_RST = 1'h0;
  localparam logic PST_ANABL_VAL = 1'h1;
  localparam logic PST_EXT_VAL = 1'h1;
  localparam logic [15:0] PST_ZERO16 = 16'h0000;

  typedef struct packed {
    logic [3:0] cap;
    logic [3:0] rsv;
    logic nopre;
    logic an_done;
    logic rflt;
    logic link;
    logic lp_rflt;
    logic [15:0] rdata;
  } pst_state_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pst_mgmt_req_s;
endpackage : pst_pkg

// [hw/pst_status.sv]
// Notes on behaviour
// - Bit 13 reports 100 Mb/s half duplex support, resets to one.
// - Bit 12 reports 10 Mb/s full duplex support, resets to one.
// - Bit 11 reports 10 Mb/s half duplex support, resets to one.
// - Capability bits 13 to 11 are writable only under override.
// - Reserved bits 10 to 7 always read zero.
// - Override-writable bits ignore writes unless override enable is one.
// - Bit 6 shows preamble-less frame acceptance, resets to zero.
// - Writing one to bit 6 under override enables preamble-less frames.
// - Negotiation complete stays zero while negotiation is disabled.
// - Negotiation complete sets only when negotiation finishes.
// - Negotiation complete latches high; a status read re-arms it from the live value.
// - A second status read returns the live unlatched condition.
// - A received code word sets remote fault to its fault flag.
// - Remote fault holds high until a read of register 1 or 17, or a code word without the fault flag, clears it.
// - A non-latching remote fault copy shows at bit 5.13.
// - Bit 3 reads one: negotiation ability.
// - Link status latches low at bit 2, mirrored at 17.0.
// - Link status re-arms from the live link monitor result on a status read.
// - The status register sits at management address one.
// - Reset loads every stored status bit with its default; bit 1 shows the live jabber input.
`timescale 1ns/1ps
`default_nettype none
module pst_status
  import pst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire pst_mgmt_req_s req,
  input wire logic override_en,
  input wire logic an_enable,
  input wire logic an_complete,
  input wire logic lcw_valid,
  input wire logic lcw_rflt,
  input wire logic link_ok,
  input wire logic jabber,
  output logic [15:0] rdata,
  output logic no_preamble_ok,
  output logic lp_remote_fault
);
  pst_state_s st_reg;
  pst_state_s st_next;

  function automatic logic hit(input pst_mgmt_req_s r, input logic [4:0] a);
    hit = r.addr == a;
  endfunction : hit

  logic rd_stat;
  logic rd_det;
  logic an_live;
  assign rd_stat = req.rd && hit(req, PST_REG_STATUS);
  assign rd_det = req.rd && hit(req, PST_REG_DETAIL);
  assign an_live = an_enable && an_complete;

  always_comb begin
    logic [15:0] v;
    v = PST_ZERO16;
    st_next = st_reg;
    v[PST_BIT_TXFD] = 1'b1;
    v[PST_BIT_TXHD:PST_BIT_THD] = st_reg.cap[2:0];
    v[PST_BIT_NOPRE] = st_reg.nopre;
    v[PST_BIT_ANDONE] = st_reg.an_done;
    v[PST_BIT_RFLT] = st_reg.rflt;
    v[PST_BIT_ANABL] = PST_ANABL_VAL;
    v[PST_BIT_LINK] = st_reg.link;
    v[PST_BIT_JAB] = jabber;
    v[PST_BIT_EXT] = PST_EXT_VAL;
    // Reserved bits are stored for test use but never read back.
    if (rd_stat) begin
      st_next.rdata = v;
    end else if (rd_det) begin
      st_next.rdata = PST_ZERO16;
      st_next.rdata[PST_DET_RFLT] = st_reg.rflt;
      st_next.rdata[PST_DET_LINK] = st_reg.link;
    end else if (req.rd && hit(req, PST_REG_REMOTE)) begin
      st_next.rdata = PST_ZERO16;
      st_next.rdata[PST_LP_RFLT] = st_reg.lp_rflt;
    end
    if (req.wr && hit(req, PST_REG_STATUS) && override_en) begin
      st_next.cap = req.wdata[PST_BIT_TXFD:PST_BIT_THD];
      st_next.rsv = req.wdata[PST_RSV_HI:PST_RSV_LO];
      st_next.nopre = req.wdata[PST_BIT_NOPRE];
    end
    // A read re-arms the latch from the live value; a new event still wins.
    if (rd_stat) begin
      st_next.an_done = an_live;
      st_next.link = link_ok;
    end
    if (rd_stat || rd_det) begin
      st_next.rflt = 1'b0;
    end
    if (an_live) begin
      st_next.an_done = 1'b1;
    end
    if (!an_enable) begin
      st_next.an_done = 1'b0;
    end
    if (!link_ok) begin
      st_next.link = 1'b0;
    end
    if (lcw_valid) begin
      st_next.lp_rflt = lcw_rflt;
      if (lcw_rflt) begin
        st_next.rflt = 1'b1;
      end else if (!(rd_stat || rd_det)) begin
        st_next.rflt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg.cap <= PST_CAP_RST;
      st_reg.rsv <= PST_RSV_RST;
      st_reg.nopre <= PST_NOPRE_RST;
      st_reg.an_done <= 1'b0;
      st_reg.rflt <= 1'b0;
      st_reg.link <= 1'b0;
      st_reg.lp_rflt <= 1'b0;
      st_reg.rdata <= PST_ZERO16;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign no_preamble_ok = st_reg.nopre;
  assign lp_remote_fault = st_reg.lp_rflt;

  AST_CAP_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
    !override_en |=> $stable(st_reg.cap)) else $error("capability changed without override");
  AST_NOPRE_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
    !override_en |=> $stable(st_reg.nopre)) else $error("preamble bit changed without override");
  AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rd_stat) |-> rdata[PST_RSV_HI:PST_RSV_LO] == 4'h0) else $error("reserved bits nonzero");
  AST_AN_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !an_enable |=> !st_reg.an_done) else $error("negotiation done while disabled");
  AST_AN_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.an_done && an_enable && !rd_stat |=> st_reg.an_done) else $error("done latch lost");
  AST_RF_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    lcw_valid && lcw_rflt |=> st_reg.rflt && st_reg.lp_rflt) else $error("remote fault not set");
  AST_LINK_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    !link_ok |=> !st_reg.link ##1 (!st_reg.link || $past(rd_stat))) else $error("link drop lost");
  AST_RD_LINK: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> rdata[PST_BIT_LINK] == $past(st_reg.link)) else $error("read data mismatch");

  // Read checks compare with the state before the read, because a read re-arms the latches.
  for (genvar gi = 0; gi < PST_BIT_TXHD - PST_BIT_THD + 1; gi++) begin : g_cap
    AST_CAP_SHOW: assert property (@(posedge mclk) disable iff (!rst_n)
      rd_stat |=> rdata[PST_BIT_THD + gi] == $past(st_reg.cap[gi]))
      else $error("capability bit misreported");
  end

  AST_CAP_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && hit(req, PST_REG_STATUS) && override_en |=>
      st_reg.cap == $past(req.wdata[PST_BIT_TXFD:PST_BIT_THD]))
    else $error("capability write under override lost");

  AST_RSV_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
    !override_en |=> $stable(st_reg.rsv))
    else $error("reserved bits changed without override");

  AST_RSV_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && hit(req, PST_REG_STATUS) && override_en |=>
      st_reg.rsv == $past(req.wdata[PST_RSV_HI:PST_RSV_LO]))
    else $error("reserved write under override lost");

  AST_NOPRE_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && hit(req, PST_REG_STATUS) && override_en |=>
      st_reg.nopre == $past(req.wdata[PST_BIT_NOPRE]))
    else $error("preamble bit write lost");

  AST_NOPRE_RD: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> rdata[PST_BIT_NOPRE] == $past(no_preamble_ok))
    else $error("preamble bit misreported");

  AST_OTHER_WR: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && !hit(req, PST_REG_STATUS) |=> $stable(st_reg.cap) && $stable(st_reg.nopre))
    else $error("write to another address changed status");

  AST_ANABL_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> rdata[PST_BIT_ANABL])
    else $error("negotiation ability not one");

  AST_FIXED_BITS: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> rdata[PST_BIT_EXT] && rdata[PST_BIT_TXFD])
    else $error("fixed one bits wrong");

  AST_T4_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> !rdata[PST_BIT_T4])
    else $error("top status bit not zero");

  AST_JAB_LIVE: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> rdata[PST_BIT_JAB] == $past(jabber))
    else $error("jabber bit misreported");

  AST_AN_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    an_enable && an_complete |=> st_reg.an_done)
    else $error("negotiation done not latched");

  AST_AN_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_reg.an_done && !(an_enable && an_complete) |=> !st_reg.an_done)
    else $error("negotiation done set early");

  AST_RD_AN: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> rdata[PST_BIT_ANDONE] == $past(st_reg.an_done))
    else $error("negotiation done misreported");

  AST_AN_REARM: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat && !(an_enable && an_complete) |=> !st_reg.an_done)
    else $error("negotiation done not re-armed");

  AST_DET_KEEP_AN: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_det && st_reg.an_done && an_enable |=> st_reg.an_done)
    else $error("detail read cleared negotiation done");

  AST_RD_RFLT: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat |=> rdata[PST_BIT_RFLT] == $past(st_reg.rflt))
    else $error("remote fault misreported");

  AST_DET_BITS: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_det |=> rdata[PST_DET_RFLT] == $past(st_reg.rflt) &&
      rdata[PST_DET_LINK] == $past(st_reg.link))
    else $error("detail bits misreported");

  AST_DET_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_det |=> rdata[PST_BIT_T4:PST_BIT_LINK] == '0)
    else $error("detail upper bits nonzero");

  AST_RF_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_stat || rd_det) && !(lcw_valid && lcw_rflt) |=> !st_reg.rflt)
    else $error("remote fault not cleared by read");

  AST_RF_SET_RD: assert property (@(posedge mclk) disable iff (!rst_n)
    lcw_valid && lcw_rflt && rd_det |=> st_reg.rflt)
    else $error("read clear beat a new remote fault");

  AST_RF_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.rflt && !rd_stat && !rd_det && !lcw_valid |=> st_reg.rflt)
    else $error("remote fault latch lost");

  AST_RF_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_n)
    lcw_valid && !lcw_rflt |=> !st_reg.rflt && !st_reg.lp_rflt)
    else $error("remote fault not following code word");

  AST_LP_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !lcw_valid |=> $stable(st_reg.lp_rflt))
    else $error("partner fault copy changed without code word");

  AST_LP_RD: assert property (@(posedge mclk) disable iff (!rst_n)
    req.rd && hit(req, PST_REG_REMOTE) |=> rdata[PST_LP_RFLT] == $past(st_reg.lp_rflt))
    else $error("partner fault copy misreported");

  AST_LP_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    req.rd && hit(req, PST_REG_REMOTE) |=>
      {rdata[PST_BIT_T4:PST_LP_RFLT + 1], rdata[PST_LP_RFLT - 1:PST_BIT_EXT]} == '0)
    else $error("partner fault word has stray bits");

  AST_LINK_REARM: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_stat && link_ok |=> st_reg.link)
    else $error("link not re-armed by read");

  AST_LINK_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_reg.link && !rd_stat |=> !st_reg.link)
    else $error("link low latch lost");

  AST_LINK_DROP_RD: assert property (@(posedge mclk) disable iff (!rst_n)
    !link_ok && rd_stat |=> !st_reg.link)
    else $error("read hid a link drop");

  AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !rd_stat && !rd_det && !(req.rd && hit(req, PST_REG_REMOTE)) |=> $stable(rdata))
    else $error("read data changed without a read");

  // This check has no disable so that it can watch the reset itself.
  AST_RESET_DEFAULTS: assert property (@(posedge mclk)
    !rst_n |=> st_reg.cap == PST_CAP_RST && st_reg.nopre == PST_NOPRE_RST && rdata == PST_ZERO16)
    else $error("reset defaults not loaded");

  COV_OVR_WR: cover property (@(posedge mclk) req.wr && override_en && hit(req, PST_REG_STATUS));
  COV_TWO_RD: cover property (@(posedge mclk) rd_stat ##1 rd_stat);
  COV_RFLT: cover property (@(posedge mclk) lcw_valid && lcw_rflt ##[1:4] rd_det);
  COV_LINK_DROP: cover property (@(posedge mclk) !link_ok ##1 rd_stat ##[1:8] rd_stat);
  COV_AN_READ: cover property (@(posedge mclk) an_live ##[1:8] rd_stat);
endmodule : pst_status
`default_nettype wire

// [sim/pst_sta_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pst_sta_model
  import pst_pkg::*;
(
  input wire logic mclk,
  output var pst_mgmt_req_s req
);
  initial req = '0;
  // A released bus shows inverted leftovers so stale values are never mistaken for live ones.
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    req <= '{rd: !w, wr: w, addr: a, wdata: {d[15:11], PST_RSV_RST, d[6:0]}};
    @(negedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : acc
endmodule : pst_sta_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pst_pkg::*;
  logic mclk = 0, rst_n = 0, ovr = 0, an_en = 0, an_cmp = 0, lv = 0, lrf = 0, lok = 1, jab = 0;
  logic [15:0] rdata;
  logic nopre, lprf;
  pst_mgmt_req_s req;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  initial forever #2 mclk = ~mclk;
  pst_sta_model i_sta (.mclk(mclk), .req(req));
  pst_status i_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .override_en(ovr),
    .an_enable(an_en), .an_complete(an_cmp), .lcw_valid(lv), .lcw_rflt(lrf),
    .link_ok(lok), .jabber(jab), .rdata(rdata), .no_preamble_ok(nopre),
    .lp_remote_fault(lprf));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  function automatic logic [15:0] sw(input logic [2:0] c, input logic n, a, r, l);
    return {2'b01, c, 4'h0, n, a, r, 1'b1, l, 2'b01};
  endfunction : sw
  task automatic rd(input logic [4:0] a);
    i_sta.acc(1'b0, a, 16'h0000);
  endtask : rd
  task automatic t_reset;
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 0), rdata);
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 1), rdata);
    chk("nopre", 16'h0000, {15'h0000, nopre});
  endtask : t_reset
  task automatic t_override;
    i_sta.acc(1'b1, PST_REG_STATUS, 16'h0040);
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 1), rdata);
    ovr = 1'b1;
    i_sta.acc(1'b1, PST_REG_STATUS, 16'h07C0);
    rd(PST_REG_STATUS);
    chk("status", sw(3'h0, 1, 0, 0, 1), rdata);
    chk("nopre", 16'h0001, {15'h0000, nopre});
    i_sta.acc(1'b1, PST_REG_STATUS, 16'h3800);
    ovr = 1'b0;
  endtask : t_override
  task automatic t_neg;
    an_en = 1'b1;
    @(negedge mclk) an_cmp = 1'b1;
    @(negedge mclk) an_cmp = 1'b0;
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 1, 0, 1), rdata);
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 1), rdata);
    an_en = 1'b0;
    an_cmp = 1'b1;
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 1), rdata);
    an_cmp = 1'b0;
  endtask : t_neg
  task automatic t_fault;
    lrf = 1'b1;
    @(negedge mclk) lv = 1'b1;
    @(negedge mclk) lv = 1'b0;
    chk("lp_rflt", 16'h0001, {15'h0000, lprf});
    rd(PST_REG_DETAIL);
    chk("detail", 16'h0003, rdata & 16'h0003);
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 1), rdata);
    lrf = 1'b0;
    @(negedge mclk) lv = 1'b1;
    @(negedge mclk) lv = 1'b0;
    chk("lp_rflt", 16'h0000, {15'h0000, lprf});
  endtask : t_fault
  task automatic t_link;
    @(negedge mclk) lok = 1'b0;
    @(negedge mclk) lok = 1'b1;
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 0), rdata);
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 1), rdata);
    jab = 1'b1;
    rd(PST_REG_STATUS);
    chk("jabber", 16'h0002, rdata & 16'h0002);
    jab = 1'b0;
  endtask : t_link
  task automatic t_rerst;
    ovr = 1'b1;
    i_sta.acc(1'b1, PST_REG_STATUS, 16'h0040);
    ovr = 1'b0;
    @(negedge mclk) rst_n = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 0), rdata);
    chk("nopre", 16'h0000, {15'h0000, nopre});
    rd(PST_REG_STATUS);
    chk("status", sw(3'h7, 0, 0, 0, 1), rdata);
  endtask : t_rerst
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_override();
    t_neg();
    t_fault();
    t_link();
    t_rerst();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
